// *** motion_regs.vh ***
// Constants for the motion event and interrupt block
`ifndef MOTION_REGS_VH
`define MOTION_REGS_VH

// Operating state select field codes
`define OPSEL_RUN       2'b01
`define OPSEL_STANDBY   2'b11
`define OPSEL_RESET     2'b11

// One-hot operating states
`define ST_STANDBY      2'b01
`define ST_RUN          2'b10

// Limit bases in sample LSB, 1024 LSB per g
`define UDZ_BASE        14'h0333
`define UDX_BASE        14'h02E1
`define RLZ_BASE        14'h0333
`define RLY_BASE        14'h02E1
`define FBZ_BASE        14'h00B2
`define SHAKE_BASE      14'h0533
`define FALL_BASE       14'h0200
`define TAP_SHIFT       3

// Orientation field codes
`define PL_UNKNOWN      3'h0
`define PL_LEFT         3'h1
`define PL_RIGHT        3'h2
`define PL_DOWN         3'h5
`define PL_UP           3'h6
`define FB_UNKNOWN      2'h0
`define FB_FRONT        2'h1
`define FB_BACK         2'h2

// Reset values
`define CFG_EN_RESET    1'b0
`define LIMIT_RESET     8'h00
`define LPF_RESET       3'h0
`define TAPSEL_RESET    3'h0

`endif

// *** motion_axis_mag.v ***
// Magnitude and sign of one signed axis sample
`timescale 1ns/1ps
`default_nettype none

module motion_axis_mag (
    input  wire [13:0] sample_i,
    output wire [13:0] mag_o,
    output wire        neg_o,
    output wire        pos_o
);

    // Full negative scale gives 8192, which still fits unsigned 14 bits
    assign mag_o = sample_i[13] ? (~sample_i + 14'h0001) : sample_i;
    assign neg_o = sample_i[13];
    assign pos_o = ~sample_i[13] & (|sample_i);

endmodule // motion_axis_mag

`default_nettype wire

// *** motion_event_interrupt_logic.v ***
// Operating state, motion event detection and interrupt pin control
`timescale 1ns/1ps
`default_nettype none
`include "motion_regs.vh"

module motion_event_interrupt_logic (
    input  wire        clk_sys_i,
    input  wire        sys_rst_i,
    input  wire        scl_i,
    input  wire        sda_i,
    input  wire        op_state_wr_i,
    input  wire [1:0]  op_state_select_i,
    input  wire        dev_read_i,
    input  wire        status_read_i,
    input  wire        cfg_wr_i,
    input  wire        front_back_irq_en_i,
    input  wire        orient_irq_en_i,
    input  wire        shake_x_irq_en_i,
    input  wire        shake_y_irq_en_i,
    input  wire        shake_z_irq_en_i,
    input  wire        tap_irq_en_i,
    input  wire        sample_update_irq_en_i,
    input  wire        irq_rate_select_i,
    input  wire [2:0]  lowpass_bandwidth_setting_i,
    input  wire        fall_irq_en_i,
    input  wire        fall_mode_sum_i,
    input  wire [2:0]  tap_axis_sel_i,
    input  wire [7:0]  updown_z_limit_i,
    input  wire [7:0]  updown_x_limit_i,
    input  wire [7:0]  rightleft_z_limit_i,
    input  wire [7:0]  rightleft_y_limit_i,
    input  wire [7:0]  frontback_z_limit_i,
    input  wire [7:0]  shake_limit_offset_i,
    input  wire [7:0]  fall_limit_offset_i,
    input  wire [7:0]  tap_limit_i,
    input  wire        sample_valid_i,
    input  wire [13:0] x_sample_i,
    input  wire [13:0] y_sample_i,
    input  wire [13:0] z_sample_i,
    output reg         irq_out_n_o,
    output reg         op_run_o,
    output reg         sample_clk_en_o,
    output reg  [1:0]  op_state_select_o,
    output reg         cfg_refused_o,
    output reg         tap_detected_o,
    output reg         shake_detected_o,
    output reg         fall_detected_o,
    output reg  [2:0]  portrait_landscape_field_o,
    output reg  [1:0]  front_back_field_o,
    output reg  [15:0] x_data_o,
    output reg  [15:0] y_data_o,
    output reg  [15:0] z_data_o
);

    localparam [1:0] ST_STANDBY = `ST_STANDBY;
    localparam [1:0] ST_RUN     = `ST_RUN;

    // Limit = base + 3 * offset, offset signed or unsigned
    function [13:0] lim3;
        input [13:0] base;
        input [7:0]  off;
        input        sgn;
        reg   [15:0] ext;
        reg   [15:0] sum;
        begin
            ext  = sgn ? {{8{off[7]}}, off} : {8'h00, off};
            sum  = {2'b00, base} + ext + {ext[14:0], 1'b0};
            lim3 = sum[13:0];
        end
    endfunction

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [1:0]  scl_meta_q;
    reg  [1:0]  sda_meta_q;
    reg         scl_q;
    reg         sda_q;
    reg         scl_prev_q;
    reg         sda_prev_q;
    reg         stop_pend_q;
    reg         fb_en_q;
    reg         pl_en_q;
    reg  [2:0]  sh_en_q;
    reg         tap_en_q;
    reg         sample_update_irq_en_q;
    reg         rate_sel_q;
    reg  [2:0]  lpf_q;
    reg         fall_en_q;
    reg         fall_sum_q;
    reg  [2:0]  tap_sel_q;
    reg  [7:0]  udz_q;
    reg  [7:0]  udx_q;
    reg  [7:0]  rlz_q;
    reg  [7:0]  rly_q;
    reg  [7:0]  fbz_q;
    reg  [7:0]  shk_q;
    reg  [7:0]  fal_q;
    reg  [7:0]  tap_q;
    reg  [7:0]  sample_update_irq_cnt_q;
    reg  [2:0]  pl_d;
    reg  [1:0]  fbf_d;

    wire [41:0] axis_all = {z_sample_i, y_sample_i, x_sample_i};
    wire [41:0] mag_all;
    wire [2:0]  neg;
    wire [2:0]  pos;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_axis
            motion_axis_mag u_mag (
                .sample_i (axis_all[gi*14 +: 14]),
                .mag_o    (mag_all[gi*14 +: 14]),
                .neg_o    (neg[gi]),
                .pos_o    (pos[gi])
            );
        end
    endgenerate

    wire [13:0] xm = mag_all[13:0];
    wire [13:0] ym = mag_all[27:14];
    wire [13:0] zm = mag_all[41:28];

    wire        run      = state_q[1];
    wire        accept   = run & sample_valid_i;
    wire [13:0] udz_lim  = lim3(`UDZ_BASE, udz_q, 1'b1);
    wire [13:0] udx_lim  = lim3(`UDX_BASE, udx_q, 1'b0);
    wire [13:0] rlz_lim  = lim3(`RLZ_BASE, rlz_q, 1'b1);
    wire [13:0] rly_lim  = lim3(`RLY_BASE, rly_q, 1'b0);
    wire [13:0] shk_lim  = lim3(`SHAKE_BASE, shk_q, 1'b1);
    wire [13:0] fal_lim  = lim3(`FALL_BASE, fal_q, 1'b1);
    wire [13:0] fbz_lim  = `FBZ_BASE + {6'h00, fbz_q} + {7'h00, fbz_q[7:1]};
    wire [13:0] tap_lim  = {3'h0, tap_q, 3'h0};

    wire ev_up    = (zm < udz_lim) & (xm > udx_lim) & neg[0];
    wire ev_down  = (zm < udz_lim) & (xm > udx_lim) & pos[0];
    wire ev_right = (zm < rlz_lim) & (ym > rly_lim) & neg[1];
    wire ev_left  = (zm < rlz_lim) & (ym > rly_lim) & pos[1];
    wire ev_front = pos[2] & (zm > fbz_lim);
    wire ev_back  = neg[2] & (zm > fbz_lim);

    wire [2:0] shk_ax = {zm > shk_lim, ym > shk_lim, xm > shk_lim};
    wire [2:0] tap_ax = {zm > tap_lim, ym > tap_lim, xm > tap_lim};
    wire [15:0] mag_sum = {2'b00, xm} + {2'b00, ym} + {2'b00, zm};
    wire fall_sum = mag_sum < {2'b00, fal_lim};
    wire fall_all = (xm < fal_lim) & (ym < fal_lim) & (zm < fal_lim);
    wire ev_fall  = fall_sum_q ? fall_sum : fall_all;
    wire ev_tap   = |(tap_ax & tap_sel_q);

    // Events only count when enabled
    wire set_shake = accept & (|(shk_ax & sh_en_q));
    wire set_tap   = accept & ev_tap & tap_en_q;
    wire set_fall  = accept & ev_fall & fall_en_q;

    always @* begin
        if (ev_left)
            pl_d = `PL_LEFT;
        else if (ev_right)
            pl_d = `PL_RIGHT;
        else if (ev_down)
            pl_d = `PL_DOWN;
        else if (ev_up)
            pl_d = `PL_UP;
        else
            pl_d = `PL_UNKNOWN;
        if (ev_front)
            fbf_d = `FB_FRONT;
        else if (ev_back)
            fbf_d = `FB_BACK;
        else
            fbf_d = `FB_UNKNOWN;
    end

    wire pl_chg = accept & pl_en_q & (pl_d != portrait_landscape_field_o);
    wire fb_chg = accept & fb_en_q & (fbf_d != front_back_field_o);

    // Update rate: every sample, or every 2^(lpf+1) samples
    wire [7:0] sample_update_irq_period = (8'h02 << lpf_q) - 8'h01;
    wire sample_update_irq_hit = ~rate_sel_q | (sample_update_irq_cnt_q == 8'h00);
    wire sample_update_irq_evt = accept & sample_update_irq_en_q & sample_update_irq_hit;

    wire irq_evt = set_shake | set_tap | set_fall | pl_chg | fb_chg | sample_update_irq_evt;

    // Operating state control
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_STANDBY: begin
                if (op_state_wr_i && op_state_select_i == `OPSEL_RUN)
                    state_d = ST_RUN;
            end
            ST_RUN: begin
                if (op_state_wr_i && op_state_select_i == `OPSEL_STANDBY)
                    state_d = ST_STANDBY;
            end
            default: begin
                state_d = ST_STANDBY;
            end
        endcase
    end

    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q           <= ST_STANDBY;
            op_state_select_o <= `OPSEL_RESET;
            op_run_o          <= 1'b0;
            sample_clk_en_o   <= 1'b0;
        end else begin
            state_q         <= state_d;
            op_run_o        <= state_d[1];
            sample_clk_en_o <= state_d[1];
            if (op_state_wr_i)
                op_state_select_o <= op_state_select_i;
        end
    end

    // Bus pins cross into the system clock; STOP is SDA rising with SCL high
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_meta_q  <= 2'b11;
            sda_meta_q  <= 2'b11;
            scl_q       <= 1'b1;
            sda_q       <= 1'b1;
            scl_prev_q  <= 1'b1;
            sda_prev_q  <= 1'b1;
            stop_pend_q <= 1'b1;
        end else begin
            scl_meta_q  <= {scl_meta_q[0], scl_i};
            sda_meta_q  <= {sda_meta_q[0], sda_i};
            scl_q       <= scl_meta_q[1];
            sda_q       <= sda_meta_q[1];
            scl_prev_q  <= scl_q;
            sda_prev_q  <= sda_q;
            if (scl_q && scl_prev_q && sda_q && !sda_prev_q)
                stop_pend_q <= 1'b1;
            else if (accept)
                stop_pend_q <= 1'b0;
        end
    end

    // Sample data only moves on after the master has left the bus
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            x_data_o <= 16'h0000;
            y_data_o <= 16'h0000;
            z_data_o <= 16'h0000;
        end else if (accept && stop_pend_q) begin
            x_data_o <= {{2{x_sample_i[13]}}, x_sample_i};
            y_data_o <= {{2{y_sample_i[13]}}, y_sample_i};
            z_data_o <= {{2{z_sample_i[13]}}, z_sample_i};
        end
    end

    // Settings change only in standby so detection never sees a half update
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fb_en_q       <= `CFG_EN_RESET;
            pl_en_q       <= `CFG_EN_RESET;
            sh_en_q       <= {3{`CFG_EN_RESET}};
            tap_en_q      <= `CFG_EN_RESET;
            sample_update_irq_en_q     <= `CFG_EN_RESET;
            rate_sel_q    <= `CFG_EN_RESET;
            lpf_q         <= `LPF_RESET;
            fall_en_q     <= `CFG_EN_RESET;
            fall_sum_q    <= `CFG_EN_RESET;
            tap_sel_q     <= `TAPSEL_RESET;
            udz_q         <= `LIMIT_RESET;
            udx_q         <= `LIMIT_RESET;
            rlz_q         <= `LIMIT_RESET;
            rly_q         <= `LIMIT_RESET;
            fbz_q         <= `LIMIT_RESET;
            shk_q         <= `LIMIT_RESET;
            fal_q         <= `LIMIT_RESET;
            tap_q         <= `LIMIT_RESET;
            cfg_refused_o <= 1'b0;
        end else begin
            cfg_refused_o <= cfg_wr_i & run;
            if (cfg_wr_i && !run) begin
                fb_en_q    <= front_back_irq_en_i;
                pl_en_q    <= orient_irq_en_i;
                sh_en_q    <= {shake_z_irq_en_i, shake_y_irq_en_i, shake_x_irq_en_i};
                tap_en_q   <= tap_irq_en_i;
                sample_update_irq_en_q  <= sample_update_irq_en_i;
                rate_sel_q <= irq_rate_select_i;
                lpf_q      <= lowpass_bandwidth_setting_i;
                fall_en_q  <= fall_irq_en_i;
                fall_sum_q <= fall_mode_sum_i;
                tap_sel_q  <= tap_axis_sel_i;
                udz_q      <= updown_z_limit_i;
                udx_q      <= updown_x_limit_i;
                rlz_q      <= rightleft_z_limit_i;
                rly_q      <= rightleft_y_limit_i;
                fbz_q      <= frontback_z_limit_i;
                shk_q      <= shake_limit_offset_i;
                fal_q      <= fall_limit_offset_i;
                tap_q      <= tap_limit_i;
            end
        end
    end

    // Update-rate divider restarts on each standby so the first sample fires
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            sample_update_irq_cnt_q <= 8'h00;
        else if (!run)
            sample_update_irq_cnt_q <= 8'h00;
        else if (accept)
            sample_update_irq_cnt_q <= (sample_update_irq_cnt_q == 8'h00) ? sample_update_irq_period : sample_update_irq_cnt_q - 8'h01;
    end

    // Latched flags: a new event beats a clearing read in the same cycle
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tap_detected_o   <= 1'b0;
            shake_detected_o <= 1'b0;
            fall_detected_o  <= 1'b0;
        end else begin
            if (set_tap)
                tap_detected_o <= 1'b1;
            else if (status_read_i)
                tap_detected_o <= 1'b0;
            if (set_shake)
                shake_detected_o <= 1'b1;
            else if (status_read_i)
                shake_detected_o <= 1'b0;
            if (set_fall)
                fall_detected_o <= 1'b1;
            else if (status_read_i)
                fall_detected_o <= 1'b0;
        end
    end

    // Orientation follows every accepted sample, held in standby
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            portrait_landscape_field_o <= `PL_UNKNOWN;
            front_back_field_o         <= `FB_UNKNOWN;
        end else if (accept) begin
            portrait_landscape_field_o <= pl_d;
            front_back_field_o         <= fbf_d;
        end
    end

    // Pin low on an event; read access or standby releases it
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            irq_out_n_o <= 1'b1;
        else if (irq_evt)
            irq_out_n_o <= 1'b0;
        else if (dev_read_i || !run)
            irq_out_n_o <= 1'b1;
    end

endmodule // motion_event_interrupt_logic

`default_nettype wire

// *** motion_event_interrupt_logic_asserts.sv ***
// Checker of state, flag and interrupt pin relations at the block ports
`timescale 1ns/1ps
`default_nettype none
module motion_event_interrupt_logic_asserts (
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic       op_state_wr_i,
    input wire logic [1:0] op_state_select_i,
    input wire logic       dev_read_i,
    input wire logic       status_read_i,
    input wire logic       cfg_wr_i,
    input wire logic       sample_valid_i,
    input wire logic       irq_out_n_o,
    input wire logic       op_run_o,
    input wire logic       sample_clk_en_o,
    input wire logic       cfg_refused_o,
    input wire logic       tap_detected_o,
    input wire logic       shake_detected_o,
    input wire logic       fall_detected_o,
    input wire logic [2:0] portrait_landscape_field_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_run_on_write: assert property (op_state_wr_i && op_state_select_i == 2'h1 |=> op_run_o)
        else $error("run state not entered");
    a_standby_on_write: assert property (op_state_wr_i && op_state_select_i == 2'h3 |=> !op_run_o)
        else $error("standby state not entered");
    a_state_holds: assert property (!op_state_wr_i |=> $stable(op_run_o))
        else $error("state changed without a write");
    a_clk_en_follows: assert property (sample_clk_en_o == op_run_o)
        else $error("sampling enable differs from state");
    a_pin_released_read: assert property (dev_read_i && !sample_valid_i |=> irq_out_n_o)
        else $error("pin not released by read access");
    a_no_irq_standby: assert property (!op_run_o |=> irq_out_n_o)
        else $error("interrupt asserted in standby");
    a_irq_has_cause: assert property ($fell(irq_out_n_o) |-> $past(sample_valid_i && op_run_o))
        else $error("interrupt without an accepted sample");
    a_flags_clear_read: assert property (status_read_i && !sample_valid_i
        |=> !(tap_detected_o || shake_detected_o || fall_detected_o))
        else $error("flags not cleared by status read");
    a_flags_held: assert property (!status_read_i
        |=> !($fell(tap_detected_o) || $fell(shake_detected_o) || $fell(fall_detected_o)))
        else $error("flag dropped without status read");
    a_refused_in_run: assert property (cfg_wr_i && op_run_o |=> cfg_refused_o)
        else $error("config write in run not refused");
    a_accepted_standby: assert property (cfg_wr_i && !op_run_o |=> !cfg_refused_o)
        else $error("config write in standby refused");
    a_fields_frozen: assert property (!op_run_o |=> $stable(portrait_landscape_field_o))
        else $error("orientation changed in standby");
endmodule // motion_event_interrupt_logic_asserts

bind motion_event_interrupt_logic motion_event_interrupt_logic_asserts u_asserts (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .op_state_wr_i(op_state_wr_i),
    .op_state_select_i(op_state_select_i), .dev_read_i(dev_read_i), .status_read_i(status_read_i),
    .cfg_wr_i(cfg_wr_i), .sample_valid_i(sample_valid_i), .irq_out_n_o(irq_out_n_o), .op_run_o(op_run_o),
    .sample_clk_en_o(sample_clk_en_o), .cfg_refused_o(cfg_refused_o), .tap_detected_o(tap_detected_o),
    .shake_detected_o(shake_detected_o), .fall_detected_o(fall_detected_o),
    .portrait_landscape_field_o(portrait_landscape_field_o));
`default_nettype wire

// *** mcu_bus_model.sv ***
// Bus controller model that frames a STOP condition on the bus pins
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_model (
    input  wire logic clk_link_i,
    input  wire logic stop_req_i,
    output var logic  scl_o,
    output var logic  sda_o,
    output var logic  stop_done_o
);
    // Lines rest high on their pull-ups; the clock only moves inside a frame
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        stop_done_o = 1'b0;
    end
    // Data rises while clock is high: a STOP between samples
    always @(posedge stop_req_i) begin
        @(posedge clk_link_i) scl_o <= 1'b0;
        @(posedge clk_link_i) sda_o <= 1'b0;
        @(posedge clk_link_i) scl_o <= 1'b1;
        @(posedge clk_link_i) sda_o <= 1'b1;
        @(posedge clk_link_i) stop_done_o <= ~stop_done_o;
    end
endmodule // mcu_bus_model
`default_nettype wire

// *** motion_event_interrupt_logic_tb.sv ***
// Self-checking bench of the motion event and interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module motion_event_interrupt_logic_tb;
    logic        clk_sys_i, sys_rst_i, clk_link, stop_req, stop_done, scl, sda;
    logic [4:0]  stb;
    logic [1:0]  sel;
    logic [15:0] cv;
    logic [63:0] lim;
    logic [13:0] xs, ys, zs;
    logic        irq_out_n_o, op_run_o, sample_clk_en_o, cfg_refused_o;
    logic        tap_detected_o, shake_detected_o, fall_detected_o;
    logic [1:0]  op_state_select_o, front_back_field_o;
    logic [2:0]  portrait_landscape_field_o;
    logic [15:0] x_data_o, y_data_o, z_data_o;
    int          failures, checked;

    mcu_bus_model u_mcu (.clk_link_i(clk_link), .stop_req_i(stop_req), .scl_o(scl), .sda_o(sda),
        .stop_done_o(stop_done));

    motion_event_interrupt_logic dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
        .op_state_wr_i(stb[0]), .op_state_select_i(sel), .dev_read_i(stb[1]),
        .status_read_i(stb[2]), .cfg_wr_i(stb[3]), .front_back_irq_en_i(cv[0]),
        .orient_irq_en_i(cv[1]), .shake_x_irq_en_i(cv[2]), .shake_y_irq_en_i(cv[3]),
        .shake_z_irq_en_i(cv[4]), .tap_irq_en_i(cv[5]), .sample_update_irq_en_i(cv[6]),
        .irq_rate_select_i(cv[7]), .lowpass_bandwidth_setting_i(cv[10:8]), .fall_irq_en_i(cv[11]),
        .fall_mode_sum_i(cv[12]), .tap_axis_sel_i(cv[15:13]), .updown_z_limit_i(lim[7:0]),
        .updown_x_limit_i(lim[15:8]), .rightleft_z_limit_i(lim[23:16]), .rightleft_y_limit_i(lim[31:24]),
        .frontback_z_limit_i(lim[39:32]), .shake_limit_offset_i(lim[47:40]),
        .fall_limit_offset_i(lim[55:48]), .tap_limit_i(lim[63:56]), .sample_valid_i(stb[4]),
        .x_sample_i(xs), .y_sample_i(ys), .z_sample_i(zs), .irq_out_n_o(irq_out_n_o),
        .op_run_o(op_run_o), .sample_clk_en_o(sample_clk_en_o), .op_state_select_o(op_state_select_o),
        .cfg_refused_o(cfg_refused_o), .tap_detected_o(tap_detected_o),
        .shake_detected_o(shake_detected_o), .fall_detected_o(fall_detected_o),
        .portrait_landscape_field_o(portrait_landscape_field_o), .front_back_field_o(front_back_field_o),
        .x_data_o(x_data_o), .y_data_o(y_data_o), .z_data_o(z_data_o));

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        clk_link = 1'b0;
        forever #32 clk_link = ~clk_link;
    end

    task give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One-cycle strobe; outputs are settled at the falling edge that ends it
    task go(input logic [4:0] s);
        @(negedge clk_sys_i);
        stb = s;
        @(negedge clk_sys_i);
        stb = 5'h00;
    endtask

    task st(input logic [1:0] v);
        sel = v;
        go(5'h01);
    endtask

    task smp(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
        xs = x;
        ys = y;
        zs = z;
        go(5'h10);
    endtask

    // Bounded wait for the frame, then the pin synchronisers' delay
    task stop;
        logic d;
        int   n;
        d = stop_done;
        stop_req = 1'b1;
        for (n = 0; n < 200 && stop_done === d; n++) @(negedge clk_sys_i);
        stop_req = 1'b0;
        if (n == 200) begin
            failures++;
            give_verdict;
        end
        repeat (4) @(negedge clk_sys_i);
    endtask

    initial begin
        failures = 0;
        checked = 0;
        sys_rst_i = 1'b1;
        stb = 5'h00;
        sel = 2'h3;
        cv = 16'h0000;
        lim = 64'h4000_0000_0000_0000;
        xs = 14'h0000;
        ys = 14'h0000;
        zs = 14'h0000;
        stop_req = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        `CHK("irq", 1'b1, irq_out_n_o)
        `CHK("run", 1'b0, op_run_o)
        `CHK("select", 2'h3, op_state_select_o)
        cv = 16'h2824;
        go(5'h08);
        `CHK("refused", 1'b0, cfg_refused_o)
        st(2'h1);
        `CHK("run", 1'b1, op_run_o)
        `CHK("clk en", 1'b1, sample_clk_en_o)
        go(5'h08);
        `CHK("refused", 1'b1, cfg_refused_o)
        smp(14'h0258, 14'h0000, 14'h0000);
        `CHK("tap", 1'b1, tap_detected_o)
        `CHK("irq", 1'b0, irq_out_n_o)
        `CHK("shake", 1'b0, shake_detected_o)
        `CHK("x data", 16'h0258, x_data_o)
        go(5'h02);
        `CHK("irq", 1'b1, irq_out_n_o)
        `CHK("tap", 1'b1, tap_detected_o)
        go(5'h04);
        `CHK("tap", 1'b0, tap_detected_o)
        smp(14'h3C00, 14'h0000, 14'h0000);
        `CHK("orient", 3'h6, portrait_landscape_field_o)
        `CHK("x data", 16'h0258, x_data_o)
        stop;
        smp(14'h0000, 14'h3C00, 14'h0000);
        `CHK("orient", 3'h2, portrait_landscape_field_o)
        `CHK("y data", 16'hFC00, y_data_o)
        smp(14'h0000, 14'h0400, 14'h0000);
        `CHK("orient", 3'h1, portrait_landscape_field_o)
        smp(14'h0400, 14'h0000, 14'h0000);
        `CHK("orient", 3'h5, portrait_landscape_field_o)
        smp(14'h0000, 14'h0000, 14'h012C);
        `CHK("front back", 2'h1, front_back_field_o)
        `CHK("orient", 3'h0, portrait_landscape_field_o)
        stop;
        smp(14'h0000, 14'h0000, 14'h3ED4);
        `CHK("front back", 2'h2, front_back_field_o)
        `CHK("z data", 16'hFED4, z_data_o)
        smp(14'h0600, 14'h0000, 14'h0000);
        `CHK("shake", 1'b1, shake_detected_o)
        `CHK("tap", 1'b1, tap_detected_o)
        go(5'h04);
        smp(14'h0190, 14'h0190, 14'h0190);
        `CHK("fall", 1'b1, fall_detected_o)
        `CHK("shake", 1'b0, shake_detected_o)
        st(2'h3);
        `CHK("run", 1'b0, op_run_o)
        // Pin lets go one cycle after the state register moves
        @(negedge clk_sys_i);
        `CHK("irq", 1'b1, irq_out_n_o)
        smp(14'h0000, 14'h0000, 14'h3ED4);
        `CHK("front back", 2'h1, front_back_field_o)
        `CHK("fall", 1'b1, fall_detected_o)
        go(5'h04);
        `CHK("fall", 1'b0, fall_detected_o)
        st(2'h0);
        `CHK("run", 1'b0, op_run_o)
        `CHK("select", 2'h0, op_state_select_o)
        cv = 16'h3840;
        go(5'h08);
        st(2'h1);
        smp(14'h0258, 14'h0190, 14'h0190);
        `CHK("tap", 1'b0, tap_detected_o)
        `CHK("fall", 1'b0, fall_detected_o)
        `CHK("irq", 1'b0, irq_out_n_o)
        go(5'h02);
        smp(14'h0000, 14'h0000, 14'h0000);
        `CHK("fall", 1'b1, fall_detected_o)
        `CHK("irq", 1'b0, irq_out_n_o)
        st(2'h3);
        cv = 16'h00C0;
        go(5'h08);
        st(2'h1);
        smp(14'h0000, 14'h0000, 14'h0000);
        `CHK("irq", 1'b0, irq_out_n_o)
        go(5'h02);
        smp(14'h0000, 14'h0000, 14'h0000);
        `CHK("irq", 1'b1, irq_out_n_o)
        smp(14'h0000, 14'h0000, 14'h0000);
        `CHK("irq", 1'b0, irq_out_n_o)
        st(2'h3);
        cv = 16'h0002;
        go(5'h08);
        st(2'h1);
        smp(14'h0400, 14'h0000, 14'h0000);
        `CHK("irq", 1'b0, irq_out_n_o)
        `CHK("orient", 3'h5, portrait_landscape_field_o)
        go(5'h02);
        smp(14'h0400, 14'h0000, 14'h0000);
        `CHK("irq", 1'b1, irq_out_n_o)
        go(5'h04);
        smp(14'h0000, 14'h0000, 14'h0000);
        `CHK("fall", 1'b0, fall_detected_o)
        give_verdict;
    end
endmodule // motion_event_interrupt_logic_tb
`default_nettype wire
